// *** monitor_regs_pkg.sv ***
`default_nettype none
package monitor_regs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL   = 8'h01;
  localparam logic [7:0] IDX_RATE   = 8'h05;
  localparam logic [7:0] IDX_FQ     = 8'h06;
  localparam logic [7:0] IDX_FAN    = 8'h07;
  localparam logic [7:0] IDX_MASK1  = 8'h08;
  localparam logic [7:0] IDX_MASK2  = 8'h09;
  localparam logic [7:0] IDX_MASK3  = 8'h0A;
  localparam logic [7:0] IDX_LIMIT  = 8'h0B;
  localparam logic [7:0] IDX_STAT1  = 8'h41;
  localparam logic [7:0] IDX_STAT2  = 8'h42;
  localparam logic [7:0] IDX_STAT3  = 8'h43;
  // Reset values
  localparam logic [7:0] RST_CTRL   = 8'h80;
  localparam logic [7:0] RST_RATE   = 8'h0A;
  localparam logic [7:0] RST_FQ     = 8'h01;
  localparam logic [7:0] RST_FAN    = 8'h09;
  localparam logic [7:0] RST_MASK1  = 8'h52;
  localparam logic [7:0] RST_MASK2  = 8'h10;
  localparam logic [7:0] RST_MASK3  = 8'h00;
  localparam logic [7:0] RST_LIMIT  = 8'h00;
  // Writable / implemented bits
  localparam logic [7:0] WM_CTRL    = 8'hD0;
  localparam logic [7:0] WM_RATE    = 8'h8F;
  localparam logic [7:0] WM_FQ      = 8'h0F;
  localparam logic [7:0] WM_FAN     = 8'h43;
  localparam logic [7:0] WM_MASK1   = 8'hF8;
  localparam logic [7:0] WM_MASK2   = 8'h1C;
  localparam logic [7:0] WM_MASK3   = 8'hC0;
  // Field positions
  localparam int CTRL_RR_BIT        = 7;
  localparam int CTRL_LOCK_BIT      = 6;
  localparam int CTRL_CHSEL_BIT     = 4;
  localparam int CTRL_REINIT_BIT    = 0;
  localparam int FAN_OFF_BIT        = 6;
  localparam int ST1_LOCAL_HIGH_BIT = 7;
  localparam int ST2_OT_STATE_BIT   = 2;
  localparam logic [3:0] RATE_MAX   = 4'hA;
  // Period of the fastest rate (64 per second)
  localparam int FAST_PERIOD_US     = 15625;
  localparam int CLK_PERIOD_NS      = 10;
  localparam int FAST_PERIOD_CYC    = FAST_PERIOD_US * 1000 / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// *** monitor_config_mask_regs.sv ***
// Operation
// - four-bit code doubles rate, 0.0625 to 64/s
// - new rate applies at next sequence start
// - fault queue depth 1,2,3,4 by pattern
// - fan-off bit forces fan off
// - source select: local, remote, or full speed
// - temperature mask bits gate interrupt only
// - overtemp and fan mask bits gate interrupt
// - overtemp state mask spares comparator alert
// - local above limit sets local-high status
// - lock bit blocks writes to lockable registers
// - software reinit restores defaults except limit and status
// - round robin alternates, else selected channel
`timescale 1ns/1ps
`default_nettype none
module monitor_config_mask_regs #(
  parameter logic [31:0] FAST_CYCLES = 32'(monitor_regs_pkg::FAST_PERIOD_CYC)
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurement and event inputs
  input  wire logic [7:0]  local_temp,
  input  wire logic        local_temp_valid,
  input  wire logic [3:0]  temp_evt,
  input  wire logic [2:0]  ot_evt,
  input  wire logic [1:0]  fan_evt,
  // Conversion scheduling
  output logic             conv_tick,
  output logic             conv_channel,
  output logic      [3:0]  conv_rate_active,
  output logic      [2:0]  fault_queue_depth,
  // Fan drive control
  output logic             fan_force_off,
  output logic      [1:0]  fan_source_select,
  output logic             fan_full_speed,
  output logic             fan_use_remote,
  // Limits and alerts
  output logic      [7:0]  local_high_limit,
  output logic             overtemp_comp_alert,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] period_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > monitor_regs_pkg::RATE_MAX) ? monitor_regs_pkg::RATE_MAX : code;
    period_of = FAST_CYCLES << (monitor_regs_pkg::RATE_MAX - c);
  endfunction

  function automatic logic [2:0] fq_depth(input logic [3:0] f);
    if (f[3])
      fq_depth = 3'h4;
    else if (f[2])
      fq_depth = 3'h3;
    else if (f[1])
      fq_depth = 3'h2;
    else
      fq_depth = 3'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl_r,  ctrl_nxt;
  logic        lock_r,  lock_nxt;
  logic [7:0]  rate_r,  rate_nxt;
  logic [7:0]  fq_r,    fq_nxt;
  logic [7:0]  fan_r,   fan_nxt;
  logic [7:0]  mask1_r, mask1_nxt;
  logic [7:0]  mask2_r, mask2_nxt;
  logic [7:0]  mask3_r, mask3_nxt;
  logic [7:0]  limit_r, limit_nxt;
  logic [7:0]  stat1_r, stat1_nxt;
  logic [7:0]  stat2_r, stat2_nxt;
  logic [7:0]  stat3_r, stat3_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        slverr_r, slverr_nxt;
  logic [7:0]  idx;
  logic        hit;
  logic        wr;
  logic        wr_ok;
  logic        reinit;
  logic [7:0]  wd;
  logic [7:0]  set1, set2, set3;

  assign idx = paddr[9:2];
  assign wd  = pwdata[7:0];

  always_comb begin
    hit = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    case (idx)
      monitor_regs_pkg::IDX_CTRL,  monitor_regs_pkg::IDX_RATE,
      monitor_regs_pkg::IDX_FQ,    monitor_regs_pkg::IDX_FAN,
      monitor_regs_pkg::IDX_MASK1, monitor_regs_pkg::IDX_MASK2,
      monitor_regs_pkg::IDX_MASK3, monitor_regs_pkg::IDX_LIMIT,
      monitor_regs_pkg::IDX_STAT1, monitor_regs_pkg::IDX_STAT2,
      monitor_regs_pkg::IDX_STAT3: ;
      default: hit = 1'b0;
    endcase
  end

  // Writes land in the access phase; only byte lane 0 carries data
  assign wr     = psel && penable && pwrite && hit && pstrb[0];
  assign wr_ok  = wr && !lock_r;
  assign reinit = wr_ok && (idx == monitor_regs_pkg::IDX_CTRL)
                  && wd[monitor_regs_pkg::CTRL_REINIT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Status set sources
  always_comb begin
    set1 = {local_temp_valid && (local_temp > limit_r), temp_evt, 3'b000};
    set2 = {3'b000, ot_evt, 2'b00};
    set3 = {fan_evt, 6'b000000};
  end

  always_comb begin
    ctrl_nxt  = ctrl_r;
    lock_nxt  = lock_r;
    rate_nxt  = rate_r;
    fq_nxt    = fq_r;
    fan_nxt   = fan_r;
    mask1_nxt = mask1_r;
    mask2_nxt = mask2_r;
    mask3_nxt = mask3_r;
    limit_nxt = limit_r;
    if (wr_ok) begin
      case (idx)
        monitor_regs_pkg::IDX_CTRL: begin
          ctrl_nxt = wd & monitor_regs_pkg::WM_CTRL;
          lock_nxt = wd[monitor_regs_pkg::CTRL_LOCK_BIT];
        end
        monitor_regs_pkg::IDX_RATE:  rate_nxt  = wd & monitor_regs_pkg::WM_RATE;
        monitor_regs_pkg::IDX_FQ:    fq_nxt    = wd & monitor_regs_pkg::WM_FQ;
        monitor_regs_pkg::IDX_FAN:   fan_nxt   = wd & monitor_regs_pkg::WM_FAN;
        default: ;
      endcase
    end
    // Masks and limit stay writable under lock
    if (wr) begin
      case (idx)
        monitor_regs_pkg::IDX_MASK1: mask1_nxt = wd & monitor_regs_pkg::WM_MASK1;
        monitor_regs_pkg::IDX_MASK2: mask2_nxt = wd & monitor_regs_pkg::WM_MASK2;
        monitor_regs_pkg::IDX_MASK3: mask3_nxt = wd & monitor_regs_pkg::WM_MASK3;
        monitor_regs_pkg::IDX_LIMIT: limit_nxt = wd;
        default: ;
      endcase
    end
    // Reinit wins over the write that carries it; limit is kept
    if (reinit) begin
      ctrl_nxt  = monitor_regs_pkg::RST_CTRL;
      lock_nxt  = 1'b0;
      rate_nxt  = monitor_regs_pkg::RST_RATE;
      fq_nxt    = monitor_regs_pkg::RST_FQ;
      fan_nxt   = monitor_regs_pkg::RST_FAN;
      mask1_nxt = monitor_regs_pkg::RST_MASK1;
      mask2_nxt = monitor_regs_pkg::RST_MASK2;
      mask3_nxt = monitor_regs_pkg::RST_MASK3;
    end
    // Set wins over a one-to-clear in the same cycle
    stat1_nxt = stat1_r;
    stat2_nxt = stat2_r;
    stat3_nxt = stat3_r;
    if (wr) begin
      case (idx)
        monitor_regs_pkg::IDX_STAT1: stat1_nxt = stat1_r & ~wd;
        monitor_regs_pkg::IDX_STAT2: stat2_nxt = stat2_r & ~wd;
        monitor_regs_pkg::IDX_STAT3: stat3_nxt = stat3_r & ~wd;
        default: ;
      endcase
    end
    stat1_nxt = (stat1_nxt | set1) & monitor_regs_pkg::WM_MASK1;
    stat2_nxt = (stat2_nxt | set2) & monitor_regs_pkg::WM_MASK2;
    stat3_nxt = (stat3_nxt | set3) & monitor_regs_pkg::WM_MASK3;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup phase, so pready never waits
  always_comb begin
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    if (psel && !penable) begin
      slverr_nxt = !hit;
      prdata_nxt = 32'h0000_0000;
      if (!pwrite && hit) begin
        case (idx)
          monitor_regs_pkg::IDX_CTRL:  prdata_nxt[7:0] = ctrl_r;
          monitor_regs_pkg::IDX_RATE:  prdata_nxt[7:0] = rate_r & monitor_regs_pkg::WM_RATE;
          monitor_regs_pkg::IDX_FQ:    prdata_nxt[7:0] = fq_r & monitor_regs_pkg::WM_FQ;
          monitor_regs_pkg::IDX_FAN:   prdata_nxt[7:0] = fan_r & monitor_regs_pkg::WM_FAN;
          monitor_regs_pkg::IDX_MASK1: prdata_nxt[7:0] = mask1_r & monitor_regs_pkg::WM_MASK1;
          monitor_regs_pkg::IDX_MASK2: prdata_nxt[7:0] = mask2_r & monitor_regs_pkg::WM_MASK2;
          monitor_regs_pkg::IDX_MASK3: prdata_nxt[7:0] = mask3_r & monitor_regs_pkg::WM_MASK3;
          monitor_regs_pkg::IDX_LIMIT: prdata_nxt[7:0] = limit_r;
          monitor_regs_pkg::IDX_STAT1: prdata_nxt[7:0] = stat1_r;
          monitor_regs_pkg::IDX_STAT2: prdata_nxt[7:0] = stat2_r;
          monitor_regs_pkg::IDX_STAT3: prdata_nxt[7:0] = stat3_r;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= monitor_regs_pkg::RST_CTRL;
      lock_r   <= 1'b0;
      rate_r   <= monitor_regs_pkg::RST_RATE;
      fq_r     <= monitor_regs_pkg::RST_FQ;
      fan_r    <= monitor_regs_pkg::RST_FAN;
      mask1_r  <= monitor_regs_pkg::RST_MASK1;
      mask2_r  <= monitor_regs_pkg::RST_MASK2;
      mask3_r  <= monitor_regs_pkg::RST_MASK3;
      limit_r  <= monitor_regs_pkg::RST_LIMIT;
      stat1_r  <= 8'h00;
      stat2_r  <= 8'h00;
      stat3_r  <= 8'h00;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      lock_r   <= lock_nxt;
      rate_r   <= rate_nxt;
      fq_r     <= fq_nxt;
      fan_r    <= fan_nxt;
      mask1_r  <= mask1_nxt;
      mask2_r  <= mask2_nxt;
      mask3_r  <= mask3_nxt;
      limit_r  <= limit_nxt;
      stat1_r  <= stat1_nxt;
      stat2_r  <= stat2_nxt;
      stat3_r  <= stat3_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = slverr_r && psel && penable;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion scheduler
  logic [31:0] cnt_r,  cnt_nxt;
  logic [3:0]  act_r,  act_nxt;
  logic        chan_r, chan_nxt;
  logic        tick_r, tick_nxt;
  logic        ch;
  logic        seq_start;

  always_comb begin
    cnt_nxt  = cnt_r;
    act_nxt  = act_r;
    chan_nxt = chan_r;
    tick_nxt = 1'b0;
    ch        = ctrl_r[monitor_regs_pkg::CTRL_RR_BIT] ? !chan_r
                : ctrl_r[monitor_regs_pkg::CTRL_CHSEL_BIT];
    // Single-channel mode: every conversion is its own sequence
    seq_start = !ctrl_r[monitor_regs_pkg::CTRL_RR_BIT] || !ch;
    if (cnt_r == 32'h0000_0000) begin
      tick_nxt = 1'b1;
      chan_nxt = ch;
      if (seq_start) begin
        act_nxt = rate_r[3:0];
        cnt_nxt = period_of(rate_r[3:0]) - 32'h0000_0001;
      end else begin
        cnt_nxt = period_of(act_r) - 32'h0000_0001;
      end
    end else begin
      cnt_nxt = cnt_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 32'h0000_0000;
      act_r  <= monitor_regs_pkg::RST_RATE[3:0];
      chan_r <= 1'b1;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      act_r  <= act_nxt;
      chan_r <= chan_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign conv_tick        = tick_r;
  assign conv_channel     = chan_r;
  assign conv_rate_active = act_r;

  ////////////////////////////////////////////////////////////////////////////
  assign fault_queue_depth = fq_depth(fq_r[3:0]);
  assign fan_force_off     = fan_r[monitor_regs_pkg::FAN_OFF_BIT];
  assign fan_source_select = fan_r[1:0];
  // Fan-off overrides only the full-speed choice; the remote decode is not gated
  assign fan_full_speed    = (fan_r[1:0] == 2'b11) && !fan_force_off;
  assign fan_use_remote    = (fan_r[1:0] == 2'b01) || (fan_r[1:0] == 2'b10);
  assign local_high_limit  = limit_r;
  // Comparator alert follows the state status ungated by its mask
  assign overtemp_comp_alert = stat2_r[monitor_regs_pkg::ST2_OT_STATE_BIT];
  assign irq = |(stat1_r & ~mask1_r & monitor_regs_pkg::WM_MASK1)
             | |(stat2_r & ~mask2_r & monitor_regs_pkg::WM_MASK2)
             | |(stat3_r & ~mask3_r & monitor_regs_pkg::WM_MASK3);

endmodule // monitor_config_mask_regs
`default_nettype wire

// *** monitor_config_mask_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module config_mask_checker #(
  parameter logic [31:0] FAST_CYCLES = 32'h8
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events
  input wire logic        local_temp_valid,
  input wire logic [3:0]  temp_evt,
  input wire logic [2:0]  ot_evt,
  input wire logic [1:0]  fan_evt,
  // Outputs under watch
  input wire logic        conv_tick,
  input wire logic [3:0]  conv_rate_active,
  input wire logic [2:0]  fault_queue_depth,
  input wire logic        fan_force_off,
  input wire logic [1:0]  fan_source_select,
  input wire logic        fan_full_speed,
  input wire logic        fan_use_remote,
  input wire logic        overtemp_comp_alert,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // Cycles since the last conversion tick
  logic [31:0] gap_r, gap_nxt;
  logic        seen_r, seen_nxt;
  always_comb begin
    gap_nxt = conv_tick ? 32'h0 : gap_r + 32'h1;
    seen_nxt = seen_r | conv_tick;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 32'h0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////
  ready_always_a: assert property (pready) else $error("pready low");
  rdata_upper_a: assert property (prdata[31:8] == 24'h0) else $error("read data upper bits set");
  slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("slverr outside access");
  depth_range_a: assert property (fault_queue_depth inside {[3'h1:3'h4]}) else $error("bad depth");
  fan_full_a: assert property (fan_full_speed == (fan_source_select == 2'h3 && !fan_force_off))
    else $error("full speed decode wrong");
  fan_remote_a: assert property (fan_use_remote == (fan_source_select inside {2'h1, 2'h2}))
    else $error("remote decode wrong");
  comp_alert_a: assert property (ot_evt[0] |=> overtemp_comp_alert) else $error("comparator alert missing");
  irq_cause_a: assert property ($rose(irq) |-> $past(local_temp_valid) || $past(temp_evt) != 4'h0
    || $past(ot_evt) != 3'h0 || $past(fan_evt) != 2'h0 || $past(pwrite) && $past(penable))
    else $error("irq without cause");
  tick_pulse_a: assert property (conv_tick |=> !conv_tick) else $error("tick longer than a cycle");
  tick_gap_a: assert property (conv_tick && seen_r |-> gap_r >= FAST_CYCLES - 32'h1)
    else $error("ticks too close");
  rate_switch_a: assert property ($changed(conv_rate_active) |-> conv_tick || $past(conv_tick))
    else $error("rate changed between ticks");
endmodule // config_mask_checker
bind monitor_config_mask_regs config_mask_checker #(.FAST_CYCLES(FAST_CYCLES)) checker_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .local_temp_valid, .temp_evt, .ot_evt, .fan_evt, .conv_tick,
  .conv_rate_active, .fault_queue_depth, .fan_force_off, .fan_source_select, .fan_full_speed, .fan_use_remote,
  .overtemp_comp_alert, .irq);
`default_nettype wire

// *** apb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  // Clock
  input  wire logic        pclk,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  // Answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {15'h0, 32'h0, 4'hF};
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, (idx == monitor_regs_pkg::IDX_RATE) ? {1'b0, d[6:0]} : d};
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave as long as it takes; only the bench timeout ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // apb_host_model
`default_nettype wire

// *** monitor_config_mask_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module monitor_config_mask_regs_tb;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} row_t;
  localparam int FAST = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, local_temp_valid, er, last_ch;
  logic        conv_tick, conv_channel, fan_force_off, fan_full_speed, fan_use_remote, overtemp_comp_alert, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, temp_evt, conv_rate_active;
  logic [2:0]  ot_evt, fault_queue_depth;
  logic [1:0]  fan_evt, fan_source_select;
  logic [7:0]  local_temp, local_high_limit;
  int          errors, checks, cyc, last_t, last_gap, tick_n;
  row_t        rows [8];
  row_t        dflt [8];
  monitor_config_mask_regs #(.FAST_CYCLES(32'(FAST))) monitor_config_mask_regs_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .local_temp, .local_temp_valid,
    .temp_evt, .ot_evt, .fan_evt, .conv_tick, .conv_channel, .conv_rate_active, .fault_queue_depth,
    .fan_force_off, .fan_source_select, .fan_full_speed, .fan_use_remote, .local_high_limit,
    .overtemp_comp_alert, .irq);
  apb_host_model host_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      complete_run();
    end
  end
  always @(negedge pclk) if (conv_tick === 1'b1) begin
    last_gap = cyc - last_t;
    last_t = cyc;
    last_ch = conv_channel;
    tick_n++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host_inst.xfer(1'b1, idx, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    host_inst.xfer(1'b0, idx, 8'h00, rd, er);
    check(rd, {24'h0, exp}, "read");
  endtask
  task automatic wait_tick();
    int n;
    n = tick_n;
    repeat (300) if (tick_n == n) @(posedge pclk);
  endtask
  // Pulse one event group while masked, then unmask, clear and remask
  task automatic evt(input int k);
    logic [7:0] st;
    st = (k == 0) ? 8'hF8 : (k == 1) ? 8'h1C : 8'hC0;
    @(posedge pclk);
    local_temp <= 8'hA6;
    local_temp_valid <= (k == 0);
    temp_evt <= {4{k == 0}};
    ot_evt <= {3{k == 1}};
    fan_evt <= {2{k == 2}};
    @(posedge pclk);
    {local_temp_valid, temp_evt, ot_evt, fan_evt} <= '0;
    @(negedge pclk);
    check({irq, overtemp_comp_alert}, {1'b0, k == 1}, "masked");
    rdc(monitor_regs_pkg::IDX_STAT1 + 8'(k), st);
    wr(monitor_regs_pkg::IDX_MASK1 + 8'(k), 8'h00);
    @(negedge pclk);
    check(irq, 1'b1, "unmasked");
    wr(monitor_regs_pkg::IDX_STAT1 + 8'(k), st);
    @(negedge pclk);
    check({irq, overtemp_comp_alert}, 2'b00, "cleared");
    wr(monitor_regs_pkg::IDX_MASK1 + 8'(k), 8'hFF);
  endtask
  task automatic defaults(input logic [7:0] lim);
    foreach (dflt[i]) rdc(dflt[i].idx, (dflt[i].idx == 8'h0B) ? lim : dflt[i].rd);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {presetn, local_temp_valid, temp_evt, ot_evt, fan_evt, local_temp} = '0;
    pclk = 1'b0;
    rows = '{'{8'h05, 8'h7F, 8'h0F}, '{8'h06, 8'hF7, 8'h07}, '{8'h07, 8'hFF, 8'h43}, '{8'h08, 8'hFF, 8'hF8},
             '{8'h09, 8'hFF, 8'h1C}, '{8'h0A, 8'hFF, 8'hC0}, '{8'h0B, 8'hA5, 8'hA5}, '{8'h20, 8'h55, 8'h00}};
    dflt = '{'{8'h01, 8'h0, 8'h80}, '{8'h05, 8'h0, 8'h0A}, '{8'h06, 8'h0, 8'h01}, '{8'h07, 8'h0, 8'h01},
             '{8'h08, 8'h0, 8'h50}, '{8'h09, 8'h0, 8'h10}, '{8'h0A, 8'h0, 8'h00}, '{8'h0B, 8'h0, 8'h00}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].rd);
      check(er, rows[i].idx == 8'h20, "slverr");
    end
    check(local_high_limit, 8'hA5, "limit output");
    for (int i = 0; i < 8; i++) begin
      wr(8'h07, {1'b0, i[2], 4'h0, i[1:0]});
      @(negedge pclk);
      check({fan_force_off, fan_full_speed, fan_use_remote, fan_source_select},
            {i[2], i[1:0] == 2'b11 && !i[2], ^i[1:0], i[1:0]}, "fan");
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h06, 8'(i));
      @(negedge pclk);
      check(fault_queue_depth, i[3] ? 3'h4 : i[2] ? 3'h3 : i[1] ? 3'h2 : 3'h1, "depth");
    end
    for (int k = 0; k < 3; k++) evt(k);
    wr(8'h01, 8'h81);
    defaults(8'hA5);
    wait_tick();
    // Write just after a local tick, so the remote reload must still use the old rate
    if (last_ch !== 1'b0) wait_tick();
    wr(8'h05, 8'h09);
    wait_tick();
    check({31'(last_gap), last_ch}, {31'(FAST), 1'b1}, "remote");
    wait_tick();
    check({31'(last_gap), last_ch}, {31'(FAST), 1'b0}, "old rate");
    wait_tick();
    check({31'(last_gap), last_ch}, {31'(2 * FAST), 1'b1}, "new rate");
    check(conv_rate_active, 4'h9, "rate");
    wr(8'h01, 8'h10);
    wait_tick();
    check({31'(last_gap), last_ch}, {31'(2 * FAST), 1'b1}, "single first");
    wait_tick();
    check({31'(last_gap), last_ch}, {31'(2 * FAST), 1'b1}, "single");
    wr(8'h01, 8'h40);
    wr(8'h05, 8'h03);
    rdc(8'h05, 8'h09);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    defaults(8'h00);
    complete_run();
  end
endmodule // monitor_config_mask_regs_tb
`default_nettype wire
